/* logic/ssfc_regs.vh */
/*
 * Constants for the SPI slave frame logic: frame layout, chip address,
 * instruction codes, verification pattern, fixed answer bytes and the
 * indices of the read selections handed to the register side.
 * Assumes it is included by bare name from the design files.
 */
`ifndef SSFC_REGS_VH
`define SSFC_REGS_VH

// Frame layout
`define SSFC_FRAME_BITS 5'h10
`define SSFC_ADDR_BITS 5'h02
`define SSFC_BYTE_BITS 5'h08
`define SSFC_CNT_MAX 5'h1F

// Chip address this slave answers to, instruction bits 7:6
`define SSFC_CHIP_ADDR 2'h0

// Instruction codes, bits 5:0 of the instruction byte
`define SSFC_OP_RD_IDENT 6'h00
`define SSFC_OP_RD_REVISION 6'h03
`define SSFC_OP_RD_DIAG 6'h09
`define SSFC_OP_RD_CONFIG 6'h30
`define SSFC_OP_RD_MONITOR 6'h3C
`define SSFC_OP_WR_CONFIG 6'h28
`define SSFC_OP_WR_MONITOR 6'h18

// Instruction classes returned by the decoder
`define SSFC_KIND_UNUSED 2'h0
`define SSFC_KIND_READ 2'h1
`define SSFC_KIND_WRITE 2'h2

// Read selections
`define SSFC_SEL_IDENT 3'h0
`define SSFC_SEL_REVISION 3'h1
`define SSFC_SEL_DIAG 3'h2
`define SSFC_SEL_CONFIG 3'h3
`define SSFC_SEL_MONITOR 3'h4

// Write selections
`define SSFC_WSEL_CONFIG 1'h0
`define SSFC_WSEL_MONITOR 1'h1

// Verification byte bits 5:1, MSB first
`define SSFC_VER_PATTERN 5'h15

// Data bytes answered after the verification byte
`define SSFC_WRITE_ANSWER 8'h00
`define SSFC_UNUSED_ANSWER 8'hFF

// Highest serial rate the master may use, in baud
`define SSFC_MAX_BAUD 2000000

`endif

/* logic/ssfc_sync.v */
/*
 * Two-flop synchroniser for a group of single-bit inputs.
 * Assumes each bit is an independent level from outside the clock domain;
 * bits are not guaranteed to arrive in the same cycle as each other.
 */
`timescale 1ns/1ps

module ssfc_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Asynchronous levels in, synchronised levels out
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;

    // First stage feeds only the second stage
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_reg <= RESET_VAL;
            sync_reg <= RESET_VAL;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;

endmodule

/* logic/ssfc_frame.v */
/*
 * SPI slave frame logic of an H-bridge driver: 16-bit frames, chip
 * address match, verification byte, answer byte, invalid-frame flag.
 * Assumes select, serial clock and serial input are pins from the master,
 * slow enough (2 MBaud at most) to be sampled by the 10 MHz system clock,
 * and that rd_data and proc_busy come from logic on the same clock.
 */
`timescale 1ns/1ps
`include "ssfc_regs.vh"

module ssfc_frame (
    // Clock and reset
    input wire clock,
    input wire rst,
    // SPI pins from the master
    input wire ss_n,
    input wire sck,
    input wire si,
    // Serial output pin, enable low while driving
    output wire so_out,
    output wire so_oe_n,
    // Read side: selection out, register byte in
    output wire [2:0] rd_sel,
    input wire [7:0] rd_data,
    // Write side: one-cycle strobe at frame end
    output wire wr_strobe,
    output wire wr_sel,
    output wire [7:0] wr_data,
    // Frame status
    input wire proc_busy,
    output wire frame_ok,
    output wire trans_fail
);

    // Frame machine states
    localparam [1:0] ST_WAIT = 2'h0;
    localparam [1:0] ST_ADDR = 2'h1;
    localparam [1:0] ST_ACTIVE = 2'h2;
    localparam [1:0] ST_IGNORE = 2'h3;

    // Instruction decoder: {kind, selection}
    function [4:0] ssfc_decode;
        input [5:0] code;
        begin
            case (code)
                `SSFC_OP_RD_IDENT: ssfc_decode = {`SSFC_KIND_READ, `SSFC_SEL_IDENT};
                `SSFC_OP_RD_REVISION: ssfc_decode = {`SSFC_KIND_READ, `SSFC_SEL_REVISION};
                `SSFC_OP_RD_DIAG: ssfc_decode = {`SSFC_KIND_READ, `SSFC_SEL_DIAG};
                `SSFC_OP_RD_CONFIG: ssfc_decode = {`SSFC_KIND_READ, `SSFC_SEL_CONFIG};
                `SSFC_OP_RD_MONITOR: ssfc_decode = {`SSFC_KIND_READ, `SSFC_SEL_MONITOR};
                `SSFC_OP_WR_CONFIG: ssfc_decode = {`SSFC_KIND_WRITE, 2'h0, `SSFC_WSEL_CONFIG};
                `SSFC_OP_WR_MONITOR: ssfc_decode = {`SSFC_KIND_WRITE, 2'h0, `SSFC_WSEL_MONITOR};
                default: ssfc_decode = {`SSFC_KIND_UNUSED, 3'h0};
            endcase
        end
    endfunction

    // Synchronised pins
    wire ss_n_s;
    wire sck_s;
    wire si_s;

    // Edge history of the synchronised pins
    reg ss_n_d_reg;
    reg sck_d_reg;

    // Frame state
    reg [1:0] state_reg;
    reg [4:0] count_reg;
    reg [7:0] rx_reg;
    reg [5:0] code_reg;
    reg [1:0] kind_reg;
    reg [7:0] vbyte_reg;
    reg [7:0] dbyte_reg;
    reg busy_seen_reg;
    reg trans_f_reg;

    // Output flops
    reg so_out_reg;
    reg so_oe_n_reg;
    reg [2:0] rd_sel_reg;
    reg wr_strobe_reg;
    reg wr_sel_reg;
    reg [7:0] wr_data_reg;
    reg frame_ok_reg;

    // Pins pass two flops before any logic sees them; fine at 2 MBaud or below
    ssfc_sync #(
        .WIDTH(3),
        .RESET_VAL(3'h4)
    ) u_sync (
        .clock(clock),
        .rst(rst),
        .async_in({ss_n, sck, si}),
        .sync_out({ss_n_s, sck_s, si_s})
    );

    // Edge detection on the synchronised levels
    wire ss_fall = ss_n_d_reg & ~ss_n_s;
    wire ss_rise = ~ss_n_d_reg & ss_n_s;
    wire sck_fall = sck_d_reg & ~sck_s & ~ss_n_s;
    wire sck_rise = ~sck_d_reg & sck_s & ~ss_n_s;

    // Count of falling edges seen, after this one
    wire [4:0] count_inc = (count_reg == `SSFC_CNT_MAX) ? count_reg : count_reg + 5'h01;

    // Instruction byte completes on the eighth falling edge
    wire [7:0] instr_byte = {rx_reg[6:0], si_s};
    wire [4:0] instr_dec = ssfc_decode(instr_byte[5:0]);

    // Answer byte chosen when the data phase starts
    reg [7:0] answer_now;
    always @* begin
        case (kind_reg)
            `SSFC_KIND_READ: answer_now = rd_data;
            `SSFC_KIND_WRITE: answer_now = `SSFC_WRITE_ANSWER;
            default: answer_now = `SSFC_UNUSED_ANSWER;
        endcase
    end

    // Bit position within the current byte, MSB first
    wire [2:0] bit_idx = ~count_reg[2:0];

    // Frame checks taken at the closing select edge
    wire frame_len_ok = (count_reg == `SSFC_FRAME_BITS);
    wire frame_valid = frame_len_ok & (kind_reg != `SSFC_KIND_UNUSED) & ~busy_seen_reg;

    // Pin edge history
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            ss_n_d_reg <= 1'b1;
            sck_d_reg <= 1'b0;
        end else begin
            ss_n_d_reg <= ss_n_s;
            sck_d_reg <= sck_s;
        end
    end

    // Frame machine, shifting and answer path
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= ST_WAIT;
            count_reg <= 5'h00;
            rx_reg <= 8'h00;
            code_reg <= 6'h00;
            kind_reg <= `SSFC_KIND_UNUSED;
            vbyte_reg <= 8'h00;
            dbyte_reg <= 8'h00;
            busy_seen_reg <= 1'b0;
            trans_f_reg <= 1'b0;
            so_out_reg <= 1'b0;
            so_oe_n_reg <= 1'b1;
            rd_sel_reg <= 3'h0;
            wr_strobe_reg <= 1'b0;
            wr_sel_reg <= 1'b0;
            wr_data_reg <= 8'h00;
            frame_ok_reg <= 1'b0;
        end else begin
            wr_strobe_reg <= 1'b0;
            frame_ok_reg <= 1'b0;
            if (ss_n_s) begin
                // Select high: release the pin and wait, whatever the progress
                state_reg <= ST_WAIT;
                so_oe_n_reg <= 1'b1;
            end
            if (ss_fall) begin
                // New frame; flag value is frozen for this verification byte
                state_reg <= ST_ADDR;
                count_reg <= 5'h00;
                rx_reg <= 8'h00;
                kind_reg <= `SSFC_KIND_UNUSED;
                vbyte_reg <= {2'h0, `SSFC_VER_PATTERN, trans_f_reg};
                busy_seen_reg <= proc_busy;
                so_oe_n_reg <= 1'b1;
            end else if (!ss_n_s) begin
                // Previous work still running at any point makes the frame invalid
                if (proc_busy) begin
                    busy_seen_reg <= 1'b1;
                end
                if (sck_fall) begin
                    count_reg <= count_inc;
                    rx_reg <= {rx_reg[6:0], si_s};
                    case (state_reg)
                        ST_ADDR: begin
                            if (count_inc == `SSFC_ADDR_BITS) begin
                                if ({rx_reg[0], si_s} == `SSFC_CHIP_ADDR) begin
                                    state_reg <= ST_ACTIVE;
                                end else begin
                                    state_reg <= ST_IGNORE;
                                end
                            end
                        end
                        ST_ACTIVE: begin
                            if (count_inc == `SSFC_BYTE_BITS) begin
                                code_reg <= instr_byte[5:0];
                                kind_reg <= instr_dec[4:3];
                                rd_sel_reg <= instr_dec[2:0];
                                // Master has latched the flag bit: now it may go
                                trans_f_reg <= 1'b0;
                            end
                        end
                        ST_IGNORE: begin
                            state_reg <= ST_IGNORE;
                        end
                        default: begin
                            state_reg <= ST_WAIT;
                        end
                    endcase
                end
                if (sck_rise && state_reg == ST_ACTIVE) begin
                    // Drive from the first bit after the address phase
                    if (count_reg >= `SSFC_ADDR_BITS && count_reg < `SSFC_FRAME_BITS) begin
                        so_oe_n_reg <= 1'b0;
                        if (count_reg < `SSFC_BYTE_BITS) begin
                            so_out_reg <= vbyte_reg[bit_idx];
                        end else if (count_reg == `SSFC_BYTE_BITS) begin
                            dbyte_reg <= answer_now;
                            so_out_reg <= answer_now[bit_idx];
                        end else begin
                            so_out_reg <= dbyte_reg[bit_idx];
                        end
                    end
                end
            end
            if (ss_rise) begin
                // Execution happens only here, and only for a matched frame
                if (state_reg == ST_ACTIVE) begin
                    if (frame_valid) begin
                        frame_ok_reg <= 1'b1;
                        // Reads never reach the write side, their data byte is dropped
                        if (kind_reg == `SSFC_KIND_WRITE) begin
                            wr_strobe_reg <= 1'b1;
                            wr_sel_reg <= code_reg == `SSFC_OP_WR_MONITOR;
                            // After sixteen falls the shifter holds the whole data byte
                            wr_data_reg <= rx_reg;
                        end
                    end else begin
                        // Set wins: flag reaches the next verification byte
                        trans_f_reg <= 1'b1;
                    end
                end
            end
        end
    end

    assign so_out = so_out_reg;
    assign so_oe_n = so_oe_n_reg;
    assign rd_sel = rd_sel_reg;
    assign wr_strobe = wr_strobe_reg;
    assign wr_sel = wr_sel_reg;
    assign wr_data = wr_data_reg;
    assign frame_ok = frame_ok_reg;
    assign trans_fail = trans_f_reg;

endmodule

/* tb/ssfc_frame_properties.sv */
/*
 * Concurrent checks on the SPI slave frame logic.
 * Bound to ssfc_frame from the bench top; sees only its ports.
 */
`timescale 1ns/1ps
`include "ssfc_regs.vh"

module ssfc_frame_properties (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Link pins
    input wire ss_n,
    input wire sck,
    input wire si,
    input wire so_out,
    input wire so_oe_n,
    // Frame results
    input wire wr_strobe,
    input wire frame_ok,
    input wire trans_fail
);
    reg sck_reg;
    reg [4:0] falls_reg;
    reg [1:0] addr_reg;

    // Raw pin view; it runs ahead of the synced view, so bounds stay safe
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            sck_reg <= 1'b0;
            falls_reg <= 5'h00;
            addr_reg <= 2'h0;
        end else begin
            sck_reg <= sck;
            if (ss_n) begin
                falls_reg <= 5'h00;
            end else if (sck_reg && !sck) begin
                falls_reg <= falls_reg + 5'h01;
                if (falls_reg < 5'h02) begin
                    addr_reg <= {addr_reg[0], si};
                end
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_idle_release: assert property (ss_n [*6] |-> so_oe_n)
        else $error("serial out driven while deselected");
    a_reset_quiet: assert property ($fell(rst) |-> so_oe_n && !trans_fail && !frame_ok)
        else $error("outputs not idle after reset");
    a_write_at_end: assert property (wr_strobe |-> ss_n && $past(ss_n, 2))
        else $error("write strobe before select rise");
    a_exec_at_end: assert property (frame_ok |-> ss_n && $past(ss_n, 2) ##1 !trans_fail)
        else $error("frame result out of place");
    a_fail_at_end: assert property ($rose(trans_fail) |-> ss_n && !frame_ok && !wr_strobe)
        else $error("failure flag set mid frame or with a valid result");
    a_fail_held: assert property ($fell(trans_fail) |-> !so_oe_n && falls_reg >= 5'h08)
        else $error("failure flag cleared before being sent");
    a_addr_first: assert property ($fell(so_oe_n) |-> !ss_n && falls_reg >= 5'h02)
        else $error("serial out driven before the address");
    a_so_on_rise: assert property ($changed(so_out) && !so_oe_n && !$past(so_oe_n) |-> $past(sck, 3))
        else $error("serial out changed away from a clock rise");
    a_foreign_quiet: assert property (!ss_n && falls_reg >= 5'h03 && addr_reg != `SSFC_CHIP_ADDR |-> so_oe_n)
        else $error("serial out driven for a foreign address");
endmodule

/* tb/ssfc_master.sv */
/*
 * Behavioural SPI master standing in for the microcontroller.
 * Assumes it is stepped from the falling edge of the 10 MHz clock.
 */
`timescale 1ns/1ps

module ssfc_master (
    // Clock and the slave's output line
    input wire clock,
    input wire so_line,
    // Pins to the slave
    output logic ss_n,
    output logic sck,
    output logic si
);
    initial begin
        ss_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end

    // Four clocks per level gives 1.25 MBaud, under the link ceiling
    task automatic frame(input logic [15:0] word, input int np, output logic [15:0] rx);
        rx = 16'hzzzz;
        @(negedge clock);
        ss_n = 1'b0;
        repeat (4) @(negedge clock);
        for (int i = 0; i < np; i++) begin
            sck = 1'b1;
            si = word[15 - (i % 16)];
            repeat (4) @(negedge clock);
            sck = 1'b0;
            repeat (4) @(negedge clock);
            // Bit launched at rise i+1 is taken after fall i+1
            if (i < 16) rx[15 - i] = so_line;
        end
        ss_n = 1'b1;
        si = ~si; // Released data does not keep its last value
        repeat (12) @(negedge clock);
    endtask
endmodule

/* tb/ssfc_frame_tb.sv */
/*
 * Self-checking bench for the SPI slave frame logic.
 * Assumes ssfc_frame, ssfc_master and the checker are compiled alongside.
 */
`timescale 1ns/1ps
`include "ssfc_regs.vh"

module ssfc_frame_tb;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic proc_busy = 1'b0;
    logic [7:0] rd_data = 8'h00;
    wire ss_n, sck, si, so_out, so_oe_n, wr_strobe, wr_sel, frame_ok, trans_fail, so_line;
    wire [2:0] rd_sel;
    wire [7:0] wr_data;
    int n_mismatch = 0;
    int tests_run = 0;
    int n_ok = 0;
    int n_wr = 0;
    localparam logic [29:0] RD_CODES = {`SSFC_OP_RD_MONITOR, `SSFC_OP_RD_CONFIG,
        `SSFC_OP_RD_DIAG, `SSFC_OP_RD_REVISION, `SSFC_OP_RD_IDENT};

    // Clock, pin level and a register side with a distinct byte per selection
    always #50 clock = ~clock;
    assign so_line = so_oe_n ? 1'bz : so_out;
    always @(negedge clock) rd_data <= 8'hC0 + {5'h00, rd_sel};

    // Result pulses are counted so each frame can be judged by difference
    always @(posedge clock) begin
        if (frame_ok === 1'b1) n_ok++;
        if (wr_strobe === 1'b1) n_wr++;
    end

    ssfc_frame u_ssfc_frame (.clock(clock), .rst(rst), .ss_n(ss_n), .sck(sck), .si(si),
        .so_out(so_out), .so_oe_n(so_oe_n), .rd_sel(rd_sel), .rd_data(rd_data),
        .wr_strobe(wr_strobe), .wr_sel(wr_sel), .wr_data(wr_data), .proc_busy(proc_busy),
        .frame_ok(frame_ok), .trans_fail(trans_fail));
    ssfc_master u_ssfc_master (.clock(clock), .so_line(so_line), .ss_n(ss_n), .sck(sck),
        .si(si));

    task chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    function logic [15:0] ver(input logic flag, input logic [7:0] data);
        return {2'bzz, `SSFC_VER_PATTERN, flag, data};
    endfunction

    // Answer bits are only checked for whole frames without busy
    task xfer(input logic [15:0] word, input int np, input logic busy, input logic [15:0] exp,
              input int d_ok, input int d_wr, input logic fail);
        logic [15:0] rx;
        int ok0;
        int wr0;
        ok0 = n_ok;
        wr0 = n_wr;
        proc_busy = busy;
        u_ssfc_master.frame(word, np, rx);
        proc_busy = 1'b0;
        if (np == 16 && !busy) chk(rx, exp);
        chk(16'(n_ok - ok0), 16'(d_ok));
        chk(16'(n_wr - wr0), 16'(d_wr));
        chk({15'h0000, trans_fail}, {15'h0000, fail});
    endtask

    task t_reset;
        chk({12'h000, so_oe_n, trans_fail, frame_ok, wr_strobe}, 16'h0008);
    endtask

    task t_reads;
        for (int i = 0; i < 5; i++) begin
            xfer({2'h0, RD_CODES[i*6 +: 6], 8'hA5}, 16, 1'b0, ver(1'b0, 8'hC0 + i[7:0]), 1, 0, 1'b0);
        end
    endtask

    task t_writes;
        xfer({2'h0, `SSFC_OP_WR_CONFIG, 8'h3C}, 16, 1'b0, ver(1'b0, 8'h00), 1, 1, 1'b0);
        chk({15'h0000, wr_sel}, {15'h0000, `SSFC_WSEL_CONFIG});
        chk({8'h00, wr_data}, 16'h003C);
        xfer({2'h0, `SSFC_OP_WR_MONITOR, 8'hC3}, 16, 1'b0, ver(1'b0, 8'h00), 1, 1, 1'b0);
        chk({15'h0000, wr_sel}, {15'h0000, `SSFC_WSEL_MONITOR});
        chk({8'h00, wr_data}, 16'h00C3);
    endtask

    task t_unused_foreign;
        xfer({2'h0, 6'h01, 8'h00}, 16, 1'b0, ver(1'b0, 8'hFF), 0, 0, 1'b1);
        for (int a = 1; a < 4; a++) begin
            xfer({a[1:0], `SSFC_OP_RD_IDENT, 8'h00}, 16, 1'b0, 16'hzzzz, 0, 0, 1'b1);
        end
        xfer({2'h0, `SSFC_OP_RD_IDENT, 8'h00}, 16, 1'b0, ver(1'b1, 8'hC0), 1, 0, 1'b0);
    endtask

    task t_bad_count;
        for (int n = 15; n < 18; n += 2) begin
            xfer({2'h0, `SSFC_OP_RD_IDENT, 8'h00}, n, 1'b0, 16'h0000, 0, 0, 1'b1);
            xfer({2'h0, `SSFC_OP_RD_DIAG, 8'h00}, 16, 1'b0, ver(1'b1, 8'hC2), 1, 0, 1'b0);
        end
    endtask

    task t_busy;
        xfer({2'h0, `SSFC_OP_WR_CONFIG, 8'h0F}, 16, 1'b1, 16'h0000, 0, 0, 1'b1);
        xfer({2'h0, `SSFC_OP_RD_IDENT, 8'h00}, 16, 1'b0, ver(1'b1, 8'hC0), 1, 0, 1'b0);
    endtask

    task finish_test;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (16) @(negedge clock);
        rst = 1'b0;
        repeat (3) @(negedge clock);
        t_reset;
        t_reads;
        t_writes;
        t_unused_foreign;
        t_bad_count;
        t_busy;
        finish_test;
    end

    // About 20 frames of 150 clocks each; a hang ends here
    initial begin
        #1000000;
        n_mismatch++;
        finish_test;
    end
endmodule

bind ssfc_frame ssfc_frame_properties u_ssfc_frame_properties (.clock(clock), .rst(rst),
    .ss_n(ss_n), .sck(sck), .si(si), .so_out(so_out), .so_oe_n(so_oe_n),
    .wr_strobe(wr_strobe), .frame_ok(frame_ok), .trans_fail(trans_fail));
